// file: rtl/pch_top.sv
`timescale 1ns/1ps
// What this block does
// [R1] While held, newly detected events no longer advance the current-interval counters.
// [R2] The interval timer keeps running while the counters are held.
// [R3] At the first interval end after a hold, the pre-hold counter values go into history.
// [R4] After that history write the current counters clear to zero even though still held.
// [R5] Every later interval end during the hold stores the zero held counters into history.
// [R6] A release resumes normal counting from that point on.
// [R7] A wipe command zeroes the missed superframe, CRC-6 and combined error event counters.
// [R8] A wipe leaves the interval timer and its elapsed time untouched.
// [R9] Counting goes on without a gap during and right after a wipe.
// [R10] While held, a held-data flag is shown next to the interval time.
// [R11] A release withdraws the held-data flag.
// [R12] Each counter set covers a fixed 900-second interval and restarts at its end.
// [R13] History keeps the last 96 intervals, from which the daily totals come.
// [R14] A wipe leaves the seconds counters and the violation counter unchanged.
// [R15] Repeated holds, or a release when not held, change nothing.
module pch_top
    import pch_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  pch_bus_t  bus,
    input  pch_evt_t  evt,
    output logic [31:0] rd_data,
    output logic      data_held,
    output pch_isec_t interval_sec
);

    typedef struct packed {
        pch_set_t    cur;
        logic        held;
        pch_hptr_t   hsel;
        logic [31:0] rd_data;
        pch_isec_t   isec_out;
    } pch_state_t;

    pch_state_t       st;
    pch_state_t       next_st;
    logic [NCNT-1:0]  evt_v;
    logic             sec_tick;
    logic             boundary;
    pch_isec_t        tmr_isec;
    pch_set_t         hist_entry;
    pch_set_t         hist_newest;
    pch_tot_t         totals;
    logic             ctrl_wr;
    logic             hold_w;
    logic             rel_w;
    logic             wipe_w;
    logic [2:0]       slot;
    logic             slot_ok;

    assign evt_v = NCNT'(evt);

    // ==========================================================
    // Interval timing and history
    pch_interval_timer #(
        .SEC_CYC (SEC_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sec_tick (sec_tick),
        .boundary (boundary),
        .isec     (tmr_isec)
    );

    pch_history u_hist (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr_en    (boundary),
        .wdata    (st.cur),
        .rd_idx   (st.hsel),
        .rd_entry (hist_entry),
        .newest   (hist_newest),
        .totals   (totals)
    );

    // ==========================================================
    // Command decode
    assign ctrl_wr = bus.wr && (bus.addr == ADDR_CTRL);
    assign hold_w  = ctrl_wr && bus.wdata[HOLD_BIT];
    assign rel_w   = ctrl_wr && bus.wdata[REL_BIT];
    assign wipe_w  = ctrl_wr && bus.wdata[WIPE_BIT];
    assign slot    = bus.addr[4:2];
    assign slot_ok = (bus.addr[1:0] == 2'h0) && (32'(slot) < NCNT);

    // ==========================================================
    // Counters, hold flag and register reads
    always_comb begin
        logic inc;
        inc     = 1'b0;
        next_st = st;
        for (int i = 0; i < NCNT; i++) begin
            inc = evt_v[i] && !st.held; // R1 R6
            if (boundary) begin
                // History already took st.cur this cycle
                next_st.cur.c[i] = inc ? CNT_W'(1) : '0; // R3 R4 R5
            end else if (wipe_w && (i < NWIPE)) begin
                next_st.cur.c[i] = inc ? CNT_W'(1) : '0; // R7 R9
            end else if (inc && (st.cur.c[i] != CNT_MAX)) begin
                // Saturates so a flood reads as max, not wrapped
                next_st.cur.c[i] = st.cur.c[i] + 1'b1; // R9 R14
            end
        end

        // Hold wins if both bits are written together
        if (hold_w) begin
            next_st.held = 1'b1; // R10 R15
        end else if (rel_w) begin
            next_st.held = 1'b0; // R11 R15
        end

        if (bus.wr && (bus.addr == ADDR_HSEL)) begin
            if (bus.wdata[HPTR_W-1:0] < HPTR_W'(HIST_DEPTH)) begin
                next_st.hsel = bus.wdata[HPTR_W-1:0];
            end
        end

        next_st.isec_out = tmr_isec; // R8
        next_st.rd_data  = '0;
        if (bus.rd) begin
            if (bus.addr == ADDR_CTRL) begin
                next_st.rd_data[HELD_BIT] = st.held; // R10
            end else if (bus.addr == ADDR_TIME) begin
                next_st.rd_data = 32'(tmr_isec);
            end else if (bus.addr == ADDR_HSEL) begin
                next_st.rd_data = 32'(st.hsel);
            end else if (((bus.addr & REGION_MASK) == CUR_BASE) && slot_ok) begin
                next_st.rd_data = 32'(st.cur.c[slot]);
            end else if (((bus.addr & REGION_MASK) == TOT_BASE) && slot_ok) begin
                next_st.rd_data = 32'(totals[slot]);
            end else if (((bus.addr & REGION_MASK) == HIST_BASE) && slot_ok) begin
                next_st.rd_data = 32'(hist_entry.c[slot]);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data      = st.rd_data;
    assign data_held    = st.held;
    assign interval_sec = st.isec_out;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence bnd_s;
        boundary;
    endsequence

    sequence held_bnd_s;
        st.held && boundary;
    endsequence

    sequence quiet_held_s;
        st.held && !boundary && !wipe_w;
    endsequence

    sequence zero_held_bnd_s;
        held_bnd_s ##0 (st.cur == '0);
    endsequence

    hold_stops_count_a: assert property ( // R1
        quiet_held_s |=> st.cur == $past(st.cur))
        else $error("held counter moved");

    held_timer_runs_a: assert property ( // R2
        st.held && sec_tick && !boundary |=> tmr_isec == $past(tmr_isec) + 1'b1)
        else $error("timer paused during hold");

    boundary_snapshot_a: assert property ( // R3
        bnd_s |=> hist_newest == $past(st.cur))
        else $error("history missed interval values");

    boundary_clear_a: assert property ( // R4
        held_bnd_s |=> st.cur == '0)
        else $error("counters not cleared at interval end");

    held_zero_entry_a: assert property ( // R5
        zero_held_bnd_s |=> hist_newest == '0)
        else $error("held interval not stored as zero");

    release_resumes_a: assert property ( // R6
        !st.held && evt_v[C_BPV] && !boundary && st.cur.c[C_BPV] != CNT_MAX
        |=> st.cur.c[C_BPV] == $past(st.cur.c[C_BPV]) + 1'b1)
        else $error("counting did not resume");

    wipe_clears_a: assert property ( // R7
        wipe_w && !boundary && (st.held || evt_v[NWIPE-1:0] == '0)
        |=> st.cur.c[C_MSF] == '0 && st.cur.c[C_CRC6] == '0 && st.cur.c[C_ERR] == '0)
        else $error("wipe left an event counter");

    wipe_time_a: assert property ( // R8
        wipe_w && !sec_tick |=> tmr_isec == $past(tmr_isec))
        else $error("wipe disturbed timer");

    wipe_no_gap_a: assert property ( // R9
        wipe_w && !st.held && evt_v[C_CRC6] && !boundary |=> st.cur.c[C_CRC6] == CNT_W'(1))
        else $error("event lost at wipe");

    held_flag_a: assert property ( // R10
        hold_w |=> data_held [*1])
        else $error("held flag not shown");

    release_flag_a: assert property ( // R11
        rel_w && !hold_w |=> !data_held)
        else $error("held flag not withdrawn");

    wipe_spares_a: assert property ( // R14
        wipe_w && !boundary && (st.held || evt_v == '0)
        |=> st.cur.c[NCNT-1:NWIPE] == $past(st.cur.c[NCNT-1:NWIPE]))
        else $error("wipe touched seconds counters");

    repeat_cmd_a: assert property ( // R15
        rel_w && !hold_w && !st.held |=> !st.held && ($stable(tmr_isec) || $past(sec_tick)))
        else $error("idle release changed state");

endmodule

// file: rtl/pch_pkg.sv
package pch_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned NCNT       = 7;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned TOT_W      = 24;
    localparam int unsigned HIST_DEPTH = 96;
    localparam int unsigned HPTR_W     = 7;
    localparam int unsigned ISEC_W     = 10;
    localparam int unsigned CYC_W      = 27;
    localparam int unsigned NWIPE      = 3;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS     = 1000000000;
    localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned INTERVAL_SEC  = 900;
    localparam logic [ISEC_W-1:0] INTV_LAST = ISEC_W'(INTERVAL_SEC - 1);

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TIME   = 8'h04;
    localparam logic [7:0] ADDR_HSEL   = 8'h08;
    localparam logic [7:0] CUR_BASE    = 8'h20;
    localparam logic [7:0] TOT_BASE    = 8'h40;
    localparam logic [7:0] HIST_BASE   = 8'h60;
    localparam logic [7:0] REGION_MASK = 8'he0;
    localparam int unsigned HOLD_BIT   = 0;
    localparam int unsigned REL_BIT    = 1;
    localparam int unsigned WIPE_BIT   = 2;
    localparam int unsigned HELD_BIT   = 0;

    // Counter slots; the wiped ones sit lowest
    localparam int unsigned C_MSF  = 0;
    localparam int unsigned C_CRC6 = 1;
    localparam int unsigned C_ERR  = 2;
    localparam int unsigned C_BPV  = 6;

    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

    typedef logic [ISEC_W-1:0] pch_isec_t;
    typedef logic [HPTR_W-1:0] pch_hptr_t;

    typedef struct packed {
        logic bpv;
        logic failed_sec;
        logic errored_sec;
        logic frame_loss_seconds;
        logic error_event;
        logic crc6_error;
        logic missed_superframe_count;
    } pch_evt_t;

    typedef struct packed {
        logic [NCNT-1:0][CNT_W-1:0] c;
    } pch_set_t;

    typedef logic [NCNT-1:0][TOT_W-1:0] pch_tot_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pch_bus_t;

endpackage

// file: rtl/pch_interval_timer.sv
`timescale 1ns/1ps
module pch_interval_timer
    import pch_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    output logic      sec_tick,
    output logic      boundary,
    output pch_isec_t isec
);

    typedef struct packed {
        logic [CYC_W-1:0] cyc;
        pch_isec_t        isec;
    } pch_tmr_t;

    pch_tmr_t st;
    pch_tmr_t next_st;
    logic     last_cyc;

    // ==========================================================
    // Free running; nothing outside can stall it
    always_comb begin
        next_st  = st;
        last_cyc = (st.cyc == CYC_W'(SEC_CYC - 1));
        if (last_cyc) begin
            next_st.cyc = '0;
            if (st.isec == INTV_LAST) begin // R12
                next_st.isec = '0;
            end else begin
                next_st.isec = st.isec + 1'b1;
            end
        end else begin
            next_st.cyc = st.cyc + 1'b1; // R2
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_tick = last_cyc;
    assign boundary = last_cyc && (st.isec == INTV_LAST);
    assign isec     = st.isec;

    timer_runs_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
        !last_cyc |=> st.cyc == $past(st.cyc) + 1'b1)
        else $error("interval timer stalled");

    interval_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        boundary |=> st.isec == '0 && st.cyc == '0)
        else $error("interval did not restart");

endmodule

// file: rtl/pch_history.sv
`timescale 1ns/1ps
module pch_history
    import pch_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic wr_en,
    input  pch_set_t  wdata,
    input  pch_hptr_t rd_idx,
    output pch_set_t  rd_entry,
    output pch_set_t  newest,
    output pch_tot_t  totals
);

    typedef struct packed {
        pch_set_t [HIST_DEPTH-1:0] mem;
        pch_hptr_t                 wptr;
        pch_tot_t                  tot;
    } pch_hst_t;

    pch_hst_t  st;
    pch_hst_t  next_st;
    pch_set_t  oldest;
    pch_hptr_t phys;
    pch_hptr_t last;

    // ==========================================================
    // Ring of intervals; daily sums kept as a running total
    // so no 96-way adder tree is needed
    always_comb begin
        next_st = st;
        oldest  = st.mem[st.wptr];
        if (wr_en) begin
            next_st.mem[st.wptr] = wdata; // R13
            next_st.wptr = (st.wptr == HPTR_W'(HIST_DEPTH - 1)) ? '0 : st.wptr + 1'b1;
            for (int i = 0; i < NCNT; i++) begin
                next_st.tot[i] = st.tot[i] + TOT_W'(wdata.c[i]) - TOT_W'(oldest.c[i]); // R13
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Index 0 is the most recent interval
    assign last     = (st.wptr == '0) ? HPTR_W'(HIST_DEPTH - 1) : st.wptr - 1'b1;
    assign phys     = (last >= rd_idx) ? last - rd_idx : last + HPTR_W'(HIST_DEPTH) - rd_idx;
    assign rd_entry = st.mem[phys];
    assign newest   = st.mem[last];
    assign totals   = st.tot;

    daily_total_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
        wr_en |=> st.tot[0] == $past(st.tot[0]) + TOT_W'($past(wdata.c[0]))
                               - TOT_W'($past(oldest.c[0])))
        else $error("daily total out of step");

endmodule

// file: tb/pch_line_src.sv
`timescale 1ns/1ps
// ==========================================================
// Line event source: a run of pulses on the masked event bits
module pch_line_src
    import pch_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       start,
    input  pch_evt_t        mask,
    input  wire logic [7:0] n,
    input  wire logic [3:0] gap,
    output pch_evt_t        evt,
    output logic            busy
);
    logic [7:0] left;
    logic [3:0] wait_cnt;

    // A gap of zero gives back-to-back pulses, a larger gap a slow line
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            left     <= 8'h00;
            wait_cnt <= 4'h0;
            busy     <= 1'b0;
            evt      <= '0;
        end else if (start && !busy) begin
            left     <= n;
            wait_cnt <= 4'h0;
            busy     <= (n != 8'h00);
            evt      <= '0;
        end else if (busy && wait_cnt == 4'h0) begin
            evt      <= mask;
            left     <= left - 8'h01;
            wait_cnt <= gap;
            busy     <= (left != 8'h01);
        end else begin
            evt      <= '0;
            if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule

// file: tb/pch_top_tb.sv
`timescale 1ns/1ps
module pch_top_tb;
    import pch_pkg::*;
    // Short seconds keep one interval at 3600 cycles
    localparam int unsigned SC = 4;

    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    pch_bus_t    bus      = '0;
    pch_evt_t    evt;
    pch_evt_t    mask     = '0;
    logic [31:0] rd_data;
    logic        data_held;
    pch_isec_t   interval_sec;
    logic        start    = 1'b0;
    logic        busy;
    logic [7:0]  n        = 8'h00;
    logic [3:0]  gap      = 4'h0;
    int          n_fail   = 0;
    int          checks_done = 0;
    int          cyc      = 0;
    int          span;
    int          span0;
    logic [15:0] exp  [NCNT];
    logic [15:0] snap [NCNT];
    pch_isec_t   t0;

    pch_top #(.SEC_CYC(SC)) dut (.core_clk(core_clk), .arst_n(arst_n), .bus(bus), .evt(evt),
        .rd_data(rd_data), .data_held(data_held), .interval_sec(interval_sec));
    pch_line_src line (.core_clk(core_clk), .arst_n(arst_n), .start(start), .mask(mask),
        .n(n), .gap(gap), .evt(evt), .busy(busy));

    always #5 core_clk = ~core_clk;

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        chk(what, e, rd_data);
    endtask

    task automatic rd_cur(input string what);
        for (int i = 0; i < NCNT; i++) begin
            rd(CUR_BASE + 8'(4 * i), 32'(exp[i]), what);
        end
    endtask

    task automatic burst(input pch_evt_t m, input logic [7:0] k, input logic [3:0] g,
                         input bit counted);
        @(posedge core_clk);
        mask  <= m;
        n     <= k;
        gap   <= g;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        for (int w = 0; w < 4000 && busy !== 1'b0; w++) begin
            @(posedge core_clk);
            #1;
        end
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < NCNT; i++) begin
            if (counted && m[i]) exp[i] += 16'(k);
        end
    endtask

    // Cycle count at which the interval time next wraps to zero
    task automatic wait_wrap(output int at);
        pch_isec_t p;
        int        c;
        c = 0;
        p = interval_sec;
        @(posedge core_clk);
        #1;
        c++;
        while (!(interval_sec == '0 && p != '0) && c < 5000) begin
            p = interval_sec;
            @(posedge core_clk);
            #1;
            c++;
        end
        at = cyc;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic end_of_test();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Hang guard, nearly three times the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        for (int i = 0; i < NCNT; i++) exp[i] = 16'h0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, 32'h0, "held flag after reset");
        rd_cur("counter after reset");
        wr(8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h0, "unmapped read");
        rd(CUR_BASE + 8'h1c, 32'h0, "spare slot read");
        // Prompt and slow event runs
        burst('1, 8'd3, 4'd0, 1'b1);
        burst(7'h55, 8'd2, 4'd5, 1'b1);
        rd_cur("counter after events");
        // Wipe keeps time, spares the other counters
        t0 = interval_sec;
        wr(ADDR_CTRL, 32'h4);
        for (int i = 0; i < NWIPE; i++) exp[i] = 16'h0;
        #1;
        chk("time after wipe", 32'h1, 32'(interval_sec >= t0 && interval_sec <= t0 + 3));
        rd_cur("counter after wipe");
        burst(7'h07, 8'd4, 4'd0, 1'b1);
        rd_cur("counter right after wipe");
        // Hold, twice over
        for (int i = 0; i < NCNT; i++) snap[i] = exp[i];
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h1);
        #1;
        chk("held pin", 32'h1, 32'(data_held));
        rd(ADDR_CTRL, 32'h1, "held flag");
        burst('1, 8'd5, 4'd1, 1'b0);
        rd_cur("counter while held");
        wr(ADDR_HSEL, 32'h0);
        wait_wrap(span0);
        for (int i = 0; i < NCNT; i++) exp[i] = 16'h0;
        for (int i = 0; i < NCNT; i++) begin
            rd(HIST_BASE + 8'(4 * i), 32'(snap[i]), "first held history");
        end
        rd_cur("counter after held boundary");
        burst('1, 8'd2, 4'd0, 1'b0);
        wait_wrap(span);
        chk("interval length", 32'(INTERVAL_SEC * SC), 32'(span - span0));
        for (int i = 0; i < NCNT; i++) begin
            rd(HIST_BASE + 8'(4 * i), 32'h0, "later held history");
        end
        wr(ADDR_HSEL, 32'h1);
        wr(ADDR_HSEL, 32'(HIST_DEPTH));
        rd(ADDR_HSEL, 32'h1, "history select");
        for (int i = 0; i < NCNT; i++) begin
            rd(HIST_BASE + 8'(4 * i), 32'(snap[i]), "older history");
            rd(TOT_BASE + 8'(4 * i), 32'(snap[i]), "daily total");
        end
        // Release, then a release while not held
        wr(ADDR_CTRL, 32'h2);
        #1;
        chk("held pin", 32'h0, 32'(data_held));
        rd(ADDR_CTRL, 32'h0, "held flag");
        burst('1, 8'd2, 4'd0, 1'b1);
        rd_cur("counter after release");
        wr(ADDR_CTRL, 32'h2);
        burst(7'h2a, 8'd1, 4'd0, 1'b1);
        rd_cur("counter after spare release");
        end_of_test();
    end
endmodule
